// [design/msra_assembler.sv]
// status record assembler: builds the record byte stream and answers the geometry query
// What this block does
// - header word bit15 set, block presence bits
// - header bytes 2-3 total length incl header
// - header sent low byte first
// - thread byte bit n thread n running
// - plane word bits 15,5,4,3
// - axis status mode and motion flags
// - axis status homing progress bits 11,10,9,1
// - switch byte latch, limits, home, stepper
// - amplifier low byte faults per group
// - amplifier bits 24,25 lockout per group
// - reported velocity is sixty-four times velocity
// - torque signed, clamped to plus/minus 32767
// - geometry query returns four bytes: axis count, then general, plane and axis block sizes
// - analog word signedness from range setting
// - axis block ends hall, reserved, user variable, then zero padding
`timescale 1ns/10ps
`default_nettype none
module msra_assembler (
   input wire logic clock,
   input wire logic rst,
   input wire logic record_request_command,
   input wire logic record_geometry_query,
   input wire logic [7:0] axis_present,
   input wire logic s_plane_present,
   input wire logic t_plane_present,
   input wire logic [7:0] thread_running,
   input wire msra_pkg::msra_plane_t plane_s,
   input wire msra_pkg::msra_plane_t plane_t,
   input wire msra_pkg::msra_amp_t amp_status,
   input wire msra_pkg::msra_axis_t axis_status [8],
   input wire logic analog_range_setting,
   output logic busy,
   output logic [7:0] out_byte,
   output logic out_valid,
   output logic out_last,
   input wire logic out_ready
);
   typedef enum logic [1:0] {
      MSRA_IDLE = 2'b00,
      MSRA_RECORD = 2'b01,
      MSRA_GEOM = 2'b10
   } msra_state_t;

   msra_state_t state;
   logic [8:0] idx;
   logic [8:0] total_len;
   logic [8:0] last_idx;
   logic [7:0] cur_byte;
   logic [4:0] sec_pos;
   logic [3:0] plane_count;
   logic [3:0] axis_count;
   logic [3:0] sec_sel;
   logic buf_in_ready;
   logic push;
   logic [8:0] buf_out;
   msra_pkg::msra_axis_t snap_axis [8];
   msra_pkg::msra_plane_t snap_s;
   msra_pkg::msra_plane_t snap_t;
   msra_pkg::msra_amp_t snap_amp;
   logic [7:0] snap_present;
   logic snap_sp;
   logic snap_tp;
   logic [7:0] snap_threads;
   logic snap_range;

   // pick byte n of a little-endian word
   function automatic logic [7:0] le_byte(input logic [31:0] w, input logic [1:0] n);
      le_byte = w[8*n +: 8];
   endfunction

   function automatic logic [15:0] plane_word(input msra_pkg::msra_plane_t p);
      plane_word = {p.move, 9'h000, p.slewing, p.stopping, p.final_decel, 3'h0};
   endfunction

   function automatic logic [15:0] axis_word(input msra_pkg::msra_axis_t a);
      // motion and mode flags, bit 12 zero
      logic [15:0] w;
      w = 16'h0000;
      w[msra_pkg::AX_MOVE] = a.move;
      w[msra_pkg::AX_RELABS] = a.rel_or_abs;
      w[msra_pkg::AX_ABS] = a.abs_only;
      w[msra_pkg::AX_COORD] = a.coord;
      w[msra_pkg::AX_NEG] = a.negative;
      w[msra_pkg::AX_CONTOUR] = a.contour;
      w[msra_pkg::AX_SLEW] = a.slewing;
      w[msra_pkg::AX_STOP] = a.stopping;
      w[msra_pkg::AX_FINAL] = a.final_decel;
      w[msra_pkg::AX_LATCH] = a.latch_armed;
      w[msra_pkg::AX_OFF] = a.motor_off;
      w[msra_pkg::AX_HOMING] = a.homing;
      w[msra_pkg::AX_HOME1] = a.home_phase1;
      w[msra_pkg::AX_HOME2] = a.home_phase2;
      w[msra_pkg::AX_HOME3] = a.home_phase3;
      axis_word = w;
   endfunction

   function automatic logic [15:0] torque_word(input logic signed [15:0] t);
      torque_word = (t < msra_pkg::TORQUE_MIN) ? msra_pkg::TORQUE_MIN : t;
   endfunction

   // unsigned range offsets by half scale
   function automatic logic [15:0] analog_word(input logic [15:0] v, input logic uns);
      analog_word = uns ? (v ^ 16'h8000) : v;
   endfunction

   // record is header, general, present planes, present axes
   always_comb begin
      plane_count = {3'h0, snap_sp} + {3'h0, snap_tp};
      axis_count = 4'h0;
      for (int i = 0; i < msra_pkg::NUM_AXES; i++) begin
         axis_count = axis_count + {3'h0, snap_present[i]};
      end
   end

   // total length includes the header
   // widened before the product: eight axis blocks overflow a byte
   assign total_len = {1'b0, msra_pkg::HEADER_BYTES} + {1'b0, msra_pkg::GENERAL_BLOCK_BYTES}
      + 9'(plane_count) * 9'(msra_pkg::PLANE_BLOCK_BYTES) + 9'(axis_count) * 9'(msra_pkg::AXIS_BLOCK_BYTES);
   assign last_idx = (state == MSRA_GEOM) ? 9'h003 : total_len - 9'h001;

   // map the running index onto a section and a position inside it
   always_comb begin
      logic [8:0] rel;
      logic [3:0] seen;
      rel = idx;
      sec_sel = 4'hF;
      sec_pos = 5'h00;
      seen = 4'h0;
      if (idx < 9'h008) begin
         sec_sel = (idx < 9'h004) ? 4'hA : 4'hB;
         sec_pos = 5'(idx[1:0]);
      end else begin
         rel = idx - 9'h008;
         if (snap_sp && rel < 9'(msra_pkg::PLANE_BLOCK_BYTES) && seen == 4'h0) begin
            sec_sel = 4'hC;
            sec_pos = rel[4:0];
            seen = 4'h1;
         end else if (snap_sp) begin
            rel = rel - 9'(msra_pkg::PLANE_BLOCK_BYTES);
         end
         if (seen == 4'h0 && snap_tp && rel < 9'(msra_pkg::PLANE_BLOCK_BYTES)) begin
            sec_sel = 4'hD;
            sec_pos = rel[4:0];
            seen = 4'h1;
         end else if (seen == 4'h0 && snap_tp) begin
            rel = rel - 9'(msra_pkg::PLANE_BLOCK_BYTES);
         end
         for (int i = 0; i < msra_pkg::NUM_AXES; i++) begin
            if (seen == 4'h0 && snap_present[i]) begin
               if (rel < 9'(msra_pkg::AXIS_BLOCK_BYTES)) begin
                  sec_sel = 4'(i);
                  sec_pos = 5'(rel);
                  seen = 4'h1;
               end else begin
                  rel = rel - 9'(msra_pkg::AXIS_BLOCK_BYTES);
               end
            end
         end
         if (seen == 4'h1 && sec_sel < 4'h8 && rel >= 9'h020) begin
            sec_pos = 5'h1F;
            sec_sel = 4'(sec_sel) | 4'h0;
         end
      end
   end

   // byte value; axis bytes 32..35 use the high position slot
   always_comb begin
      logic [15:0] hw;
      logic [15:0] aw;
      logic [15:0] tw;
      logic [15:0] anw;
      msra_pkg::msra_axis_t a;
      hw = 16'h0000;
      a = snap_axis[sec_sel[2:0]];
      aw = axis_word(a);
      tw = torque_word(a.torque);
      anw = analog_word(a.analog, snap_range);
      cur_byte = 8'h00;
      if (state == MSRA_GEOM) begin
         case (idx[1:0])
            2'h0: cur_byte = 8'(msra_pkg::NUM_AXES);
            2'h1: cur_byte = msra_pkg::GENERAL_BLOCK_BYTES;
            2'h2: cur_byte = msra_pkg::PLANE_BLOCK_BYTES;
            default: cur_byte = msra_pkg::AXIS_BLOCK_BYTES;
         endcase
      end else begin
         case (sec_sel)
            4'hA: begin
               hw = {1'b1, 5'h00, snap_tp, snap_sp, snap_present};
               cur_byte = (sec_pos[1:0] == 2'h0) ? hw[7:0] :
                  (sec_pos[1:0] == 2'h1) ? hw[15:8] :
                  le_byte({23'h0, total_len}, {1'b0, sec_pos[0]});
            end
            4'hB: begin
               cur_byte = (sec_pos[1:0] == 2'h0) ? snap_threads : 8'h00;
            end
            4'hC, 4'hD: begin
               hw = plane_word((sec_sel == 4'hC) ? snap_s : snap_t);
               cur_byte = (sec_pos < 5'h02) ? hw[8*sec_pos[0] +: 8] : 8'h00;
            end
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
               case (sec_pos)
                  5'h00: cur_byte = aw[7:0];
                  5'h01: cur_byte = aw[15:8];
                  // switch byte, bits 5 and 4 zero
                  5'h02: cur_byte = {a.latch_occurred, a.latch_level, 2'h0,
                     a.fwd_limit, a.rev_limit, a.home_level, a.stepper};
                  5'h03: cur_byte = {snap_amp.fault_eh, snap_amp.fault_ad};
                  5'h04: cur_byte = snap_amp.hall_err;
                  5'h05: cur_byte = snap_amp.peak_cur;
                  5'h06: cur_byte = {6'h00, snap_amp.lockout_eh, snap_amp.lockout_ad};
                  5'h08, 5'h09, 5'h0A, 5'h0B:
                     cur_byte = le_byte(a.velocity <<< msra_pkg::VEL_SHIFT, 2'(sec_pos - 5'h08));
                  5'h0C, 5'h0D: cur_byte = tw[8*sec_pos[0] +: 8];
                  5'h0E, 5'h0F: cur_byte = anw[8*sec_pos[0] +: 8];
                  5'h10: cur_byte = a.hall;
                  5'h11: cur_byte = 8'h00;
                  5'h12, 5'h13, 5'h14, 5'h15:
                     cur_byte = le_byte(a.user_var, 2'(sec_pos - 5'h12));
                  default: cur_byte = 8'h00;
               endcase
            end
            default: cur_byte = 8'h00;
         endcase
      end
   end

   assign push = (state != MSRA_IDLE);
   assign busy = push;

   // snapshot so one record stays coherent while it drains
   always_ff @(posedge clock) begin
      if (state == MSRA_IDLE && record_request_command) begin
         snap_axis <= axis_status;
         snap_s <= plane_s;
         snap_t <= plane_t;
         snap_amp <= amp_status;
         snap_present <= axis_present;
         snap_sp <= s_plane_present;
         snap_tp <= t_plane_present;
         snap_threads <= thread_running;
         snap_range <= analog_range_setting;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= MSRA_IDLE;
         idx <= 9'h000;
      end else begin
         case (state)
            MSRA_IDLE: begin
               idx <= 9'h000;
               if (record_request_command) begin
                  state <= MSRA_RECORD;
               end else if (record_geometry_query) begin
                  state <= MSRA_GEOM;
               end
            end
            MSRA_RECORD, MSRA_GEOM: begin
               if (buf_in_ready) begin
                  idx <= idx + 9'h001;
                  if (idx == last_idx) begin
                     state <= MSRA_IDLE;
                  end
               end
            end
            default: state <= MSRA_IDLE;
         endcase
      end
   end

   msra_buffer u_buffer (
      .clock(clock),
      .rst(rst),
      .in_data({idx == last_idx, cur_byte}),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .out_data(buf_out),
      .out_valid(out_valid),
      .out_ready(out_ready)
   );
   assign out_byte = buf_out[7:0];
   assign out_last = buf_out[8];

   // checks
   chk_geom_len: assert property (@(posedge clock) disable iff (rst)
      state == MSRA_IDLE && !record_request_command && record_geometry_query |=> (state == MSRA_GEOM) [*4])
      else $error("geometry query not started");
   chk_hdr_mark: assert property (@(posedge clock) disable iff (rst)
      push && state == MSRA_RECORD && idx == 9'h001 |-> cur_byte[7])
      else $error("header marker missing");
   chk_len_low: assert property (@(posedge clock) disable iff (rst)
      push && state == MSRA_RECORD && idx == 9'h002 |-> cur_byte == total_len[7:0])
      else $error("length low byte");
   chk_len_high: assert property (@(posedge clock) disable iff (rst)
      push && state == MSRA_RECORD && idx == 9'h003 |-> cur_byte == {7'h00, total_len[8]})
      else $error("length high");
   chk_geom_first: assert property (@(posedge clock) disable iff (rst)
      state == MSRA_GEOM && idx == 9'h000 |-> cur_byte == 8'(msra_pkg::NUM_AXES))
      else $error("axis count byte");
   chk_thread_byte: assert property (@(posedge clock) disable iff (rst)
      state == MSRA_RECORD && idx == 9'h004 |-> cur_byte == snap_threads)
      else $error("thread byte");
   chk_amp_lock: assert property (@(posedge clock) disable iff (rst)
      state == MSRA_RECORD && sec_sel < 4'h8 && sec_pos == 5'h06 |-> cur_byte[7:2] == 6'h00)
      else $error("amp top");
   chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
      state == MSRA_RECORD && sec_sel < 4'h8 && sec_pos == 5'h11 |-> cur_byte == 8'h00)
      else $error("reserved");
   chk_len_bound: assert property (@(posedge clock) disable iff (rst)
      busy |-> total_len <= msra_pkg::MAX_LEN)
      else $error("record too long");
   cov_record: cover property (@(posedge clock) disable iff (rst) state == MSRA_RECORD && idx == last_idx);
   cov_geom: cover property (@(posedge clock) disable iff (rst) state == MSRA_GEOM && idx == 9'h003);
   cov_stall: cover property (@(posedge clock) disable iff (rst) out_valid && !out_ready ##1 !buf_in_ready);
endmodule
`default_nettype wire

// [design/msra_pkg.sv]
// package: record layout constants and status carriers for the status record assembler
package msra_pkg;
   localparam int NUM_AXES = 8;
   localparam logic [7:0] AXIS_BLOCK_BYTES = 8'h24;
   localparam logic [7:0] PLANE_BLOCK_BYTES = 8'h10;
   localparam logic [7:0] GENERAL_BLOCK_BYTES = 8'h04;
   localparam logic [7:0] HEADER_BYTES = 8'h04;
   localparam int HDR_MARK_BIT = 15;
   localparam int HDR_S_BIT = 8;
   localparam int HDR_T_BIT = 9;
   localparam int AX_MOVE = 15;
   localparam int AX_RELABS = 14;
   localparam int AX_ABS = 13;
   localparam int AX_HOMING = 11;
   localparam int AX_HOME1 = 10;
   localparam int AX_HOME2 = 9;
   localparam int AX_COORD = 8;
   localparam int AX_NEG = 7;
   localparam int AX_CONTOUR = 6;
   localparam int AX_SLEW = 5;
   localparam int AX_STOP = 4;
   localparam int AX_FINAL = 3;
   localparam int AX_LATCH = 2;
   localparam int AX_HOME3 = 1;
   localparam int AX_OFF = 0;
   localparam int VEL_SHIFT = 6;
   localparam logic signed [15:0] TORQUE_MAX = 16'sh7FFF;
   localparam logic signed [15:0] TORQUE_MIN = -16'sh7FFF;
   localparam logic [8:0] MAX_LEN = 9'h174;

   typedef struct packed {
      logic move;
      logic slewing;
      logic stopping;
      logic final_decel;
   } msra_plane_t;

   typedef struct packed {
      logic move;
      logic rel_or_abs;
      logic abs_only;
      logic homing;
      logic home_phase1;
      logic home_phase2;
      logic coord;
      logic negative;
      logic contour;
      logic slewing;
      logic stopping;
      logic final_decel;
      logic latch_armed;
      logic home_phase3;
      logic motor_off;
      logic latch_occurred;
      logic latch_level;
      logic fwd_limit;
      logic rev_limit;
      logic home_level;
      logic stepper;
      logic [7:0] hall;
      logic signed [31:0] velocity;
      logic signed [15:0] torque;
      logic [15:0] analog;
      logic signed [31:0] user_var;
   } msra_axis_t;

   typedef struct packed {
      logic [3:0] fault_ad;
      logic [3:0] fault_eh;
      logic [7:0] hall_err;
      logic [7:0] peak_cur;
      logic lockout_ad;
      logic lockout_eh;
   } msra_amp_t;
endpackage

// [design/msra_buffer.sv]
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module msra_buffer (
   input wire logic clock,
   input wire logic rst,
   input wire logic [8:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [8:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [8:0] slot [2];
   logic [1:0] count;
   logic wr_ptr;
   logic rd_ptr;
   logic push;
   logic pop;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         slot[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         count <= 2'h0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

// [dv/msra_host.sv]
// host model: drains the record stream, optionally stalling
`timescale 1ns/10ps
`default_nettype none
module msra_host (
   input wire logic clock,
   input wire logic clear,
   input wire logic [1:0] mode,
   input wire logic [7:0] out_byte,
   input wire logic out_valid,
   input wire logic out_last,
   output logic out_ready,
   output logic done,
   output logic hold_err,
   output logic [15:0] count
);
   logic [7:0] got [0:511];
   logic [1:0] phase;
   logic [7:0] held;
   logic waiting;
   initial begin
      out_ready = 1'b0;
      done = 1'b0;
      hold_err = 1'b0;
      count = 16'h0000;
      phase = 2'h0;
      waiting = 1'b0;
      held = 8'h00;
   end
   // mode 1 takes one byte in four, so the buffer fills and must hold
   always @(posedge clock) begin
      phase <= phase + 2'h1;
      out_ready <= (mode == 2'h0) || (phase == 2'h3);
      waiting <= out_valid && !out_ready;
      held <= out_byte;
      if (waiting && out_valid && out_byte !== held) begin
         hold_err <= 1'b1;
      end
      if (clear) begin
         count <= 16'h0000;
         done <= 1'b0;
      end else if (out_valid && out_ready && !done) begin
         got[count[8:0]] <= out_byte;
         count <= count + 16'h0001;
         if (out_last) begin
            done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [dv/msra_assembler_tb.sv]
// self-checking bench for the status record assembler
`timescale 1ns/10ps
`default_nettype none
module msra_assembler_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic record_request_command = 1'b0;
   logic record_geometry_query = 1'b0;
   logic [7:0] axis_present = 8'h00;
   logic s_plane_present = 1'b0;
   logic t_plane_present = 1'b0;
   logic [7:0] thread_running = 8'h00;
   msra_pkg::msra_plane_t plane_s = '0;
   msra_pkg::msra_plane_t plane_t = '0;
   msra_pkg::msra_amp_t amp_status = '0;
   msra_pkg::msra_axis_t axis_status [8] = '{default: '0};
   logic analog_range_setting = 1'b0;
   logic busy, out_valid, out_last, out_ready, host_done, hold_err;
   logic [7:0] out_byte;
   logic [15:0] host_count;
   logic host_clear = 1'b0;
   logic [1:0] host_mode = 2'h0;
   logic [7:0] exp_q [$];
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;

   msra_assembler dut (.clock(clock), .rst(rst), .record_request_command(record_request_command),
      .record_geometry_query(record_geometry_query), .axis_present(axis_present),
      .s_plane_present(s_plane_present), .t_plane_present(t_plane_present), .thread_running(thread_running),
      .plane_s(plane_s), .plane_t(plane_t), .amp_status(amp_status), .axis_status(axis_status),
      .analog_range_setting(analog_range_setting), .busy(busy), .out_byte(out_byte), .out_valid(out_valid),
      .out_last(out_last), .out_ready(out_ready));
   msra_host host (.clock(clock), .clear(host_clear), .mode(host_mode), .out_byte(out_byte),
      .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready), .done(host_done),
      .hold_err(hold_err), .count(host_count));

   always #4 clock = ~clock;

   task automatic results();
      if (failures == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ceiling well above the longest stalled record
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         results();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks_done = checks_done + 1;
      if (seen !== want) begin
         failures = failures + 1;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask

   task automatic push_le(input logic [31:0] v, input int n);
      for (int k = 0; k < n; k++) begin
         // bytes past the word are zero padding
         exp_q.push_back((k < 4) ? v[8*k +: 8] : 8'h00);
      end
   endtask

   task automatic build_record();
      logic [15:0] len;
      logic [15:0] trq;
      msra_pkg::msra_axis_t a;
      exp_q.delete();
      len = 16'h0008 + 16'h0010 * (s_plane_present + t_plane_present);
      for (int i = 0; i < 8; i++) begin
         len = len + (axis_present[i] ? 16'h0024 : 16'h0000);
      end
      push_le({16'h0000, 1'b1, 5'h00, t_plane_present, s_plane_present, axis_present}, 2);
      push_le({16'h0000, len}, 2);
      push_le({24'h000000, thread_running}, 4);
      if (s_plane_present) begin
         push_le({16'h0000, plane_s.move, 9'h000, plane_s.slewing, plane_s.stopping, plane_s.final_decel, 3'h0}, 16);
      end
      if (t_plane_present) begin
         push_le({16'h0000, plane_t.move, 9'h000, plane_t.slewing, plane_t.stopping, plane_t.final_decel, 3'h0}, 16);
      end
      for (int i = 0; i < 8; i++) begin
         a = axis_status[i];
         trq = (a.torque == 16'h8000) ? 16'h8001 : a.torque;
         if (axis_present[i]) begin
            push_le({16'h0000, a.move, a.rel_or_abs, a.abs_only, 1'b0, a.homing, a.home_phase1, a.home_phase2,
               a.coord, a.negative, a.contour, a.slewing, a.stopping, a.final_decel, a.latch_armed,
               a.home_phase3, a.motor_off}, 2);
            push_le({24'h000000, a.latch_occurred, a.latch_level, 2'h0, a.fwd_limit, a.rev_limit,
               a.home_level, a.stepper}, 1);
            push_le({6'h00, amp_status.lockout_eh, amp_status.lockout_ad, amp_status.peak_cur,
               amp_status.hall_err, amp_status.fault_eh, amp_status.fault_ad}, 5);
            push_le({a.velocity[25:0], 6'h00}, 4);
            push_le({16'h0000, trq}, 2);
            push_le({16'h0000, analog_range_setting ? (a.analog ^ 16'h8000) : a.analog}, 2);
            push_le({24'h000000, a.hall}, 2);
            push_le(a.user_var, 4);
            push_le(32'h00000000, 14);
         end
      end
   endtask

   task automatic load(input logic [31:0] p, input logic [7:0] ax, input logic s, input logic t,
         input logic rng, input logic edge_trq);
      logic [127:0] w;
      @(posedge clock);
      axis_present <= ax;
      s_plane_present <= s;
      t_plane_present <= t;
      analog_range_setting <= rng;
      thread_running <= p[15:8];
      plane_s <= p[3:0];
      plane_t <= p[7:4];
      amp_status <= p[25:0] ^ 26'h2A5C3E1;
      for (int i = 0; i < 8; i++) begin
         w = {4{p ^ (32'h13579BDF * i)}};
         // most negative code on axis A
         if (edge_trq && i == 0) begin
            w[63:48] = 16'h8000;
         end
         axis_status[i] <= w[124:0];
      end
   endtask

   task automatic run(input logic geo, input logic [1:0] mode);
      int n;
      @(posedge clock);
      host_mode <= mode;
      host_clear <= 1'b1;
      @(posedge clock);
      host_clear <= 1'b0;
      record_geometry_query <= geo;
      record_request_command <= !geo;
      @(posedge clock);
      record_geometry_query <= 1'b0;
      record_request_command <= 1'b0;
      @(negedge clock);
      check(busy, 16'h0001);
      exp_q.delete();
      if (geo) begin
         push_le(32'h24100408, 4);
      end else begin
         build_record();
      end
      n = 0;
      while (host_done !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      check(host_count, 16'(exp_q.size()));
      foreach (exp_q[k]) check(host.got[k], exp_q[k]);
   endtask

   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      check({busy, out_valid}, 16'h0000);
      load(32'hA5C30F1E, 8'hFF, 1'b1, 1'b1, 1'b0, 1'b0);
      run(1'b0, 2'h0);
      load(32'h5A3CF0E1, 8'h89, 1'b0, 1'b1, 1'b1, 1'b1);
      run(1'b0, 2'h1);
      run(1'b1, 2'h1);
      load(32'h00000000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
      run(1'b0, 2'h0);
      load(32'hFFFFFFFF, 8'h81, 1'b1, 1'b0, 1'b0, 1'b0);
      run(1'b0, 2'h1);
      // reset in mid-record drops the stream
      @(posedge clock);
      record_request_command <= 1'b1;
      @(posedge clock);
      record_request_command <= 1'b0;
      repeat (5) @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      check({busy, out_valid}, 16'h0000);
      load(32'h0F1E2D3C, 8'h42, 1'b1, 1'b1, 1'b1, 1'b0);
      run(1'b0, 2'h0);
      check(hold_err, 16'h0000);
      results();
   end
endmodule
`default_nettype wire
